// [design/gpr_regs_top.sv]
// remap window config registers, TLB translation and graphics grant logic
module gpr_regs_top #(
	parameter logic [15:0] FIXED_DEVICE_ID = 16'h5a5a // arbitrary value
) (
	input  wire logic             CLOCK,
	input  wire logic             RSTN,
	input  wire logic             WB_CYC_I,
	input  wire logic             WB_STB_I,
	input  wire logic             WB_WE_I,
	input  wire logic [31:0]      WB_ADR_I,
	input  wire logic [3:0]       WB_SEL_I,
	input  wire logic [31:0]      WB_DAT_I,
	output logic      [31:0]      WB_DAT_O,
	output logic                  WB_ACK_O,
	input  wire logic             XLAT_REQ_VALID,
	input  wire gpr_pkg::gpr_req_t XLAT_REQ,
	output logic                  XLAT_READY,
	output logic                  XLAT_ANS_VALID,
	output gpr_pkg::gpr_ans_t     XLAT_ANS,
	output logic                  FETCH_REQ,
	output logic      [31:0]      FETCH_ADDR,
	input  wire logic             FETCH_ACK,
	input  wire logic [31:0]      FETCH_DATA,
	input  wire logic             DRAM_IDLE,
	input  wire logic             PORT_DISABLE_STRAP,
	input  wire logic             GRAPHICS_REQUEST_IN_N,
	input  wire logic             PEER_REQUEST,
	input  wire logic             DATA_PHASE_READY,
	output logic                  GRAPHICS_GRANT_OUT_N,
	output logic                  PEER_GRANT,
	output logic                  IN_ORDER_MODE,
	output logic                  TURNAROUND_1T,
	output logic      [3:0]       DATA_LATENCY,
	output logic                  FIRST_READY_SEL,
	output logic                  DRAM_LATCH_EXTERNAL,
	output logic      [7:0]       DRAM_ARB_TIMER,
	output logic      [7:0]       VIDEO_TIMER,
	output logic                  PORT_ENABLE,
	output logic                  SIDEBAND_ENABLE,
	output logic      [2:0]       RATE_ENABLE
);
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_FETCH} gpr_state_t;

	function automatic logic [31:0] wmerge(input logic [31:0] old,
	                                       input logic [31:0] wd,
	                                       input logic [3:0]  sel,
	                                       input logic [31:0] msk);
		logic [31:0] bm;
		bm = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & msk;
		wmerge = (old & ~bm) | (wd & bm);
	endfunction

	logic [31:0] win_base_ff, tlb_ctl_ff, size_ff, tbl_base_ff, cmd_ff;
	logic [31:0] ctl_ff, lat_ff, misc_ff, pad_ff, drive_ff, delay_ff;
	logic [31:0] latch_ff, scr_lo_ff, scr_hi_ff, dtim_ff, vtim_ff;
	logic [31:0] ov1_ff, ov2_ff, ovid_ff;
	logic        strap_ff, strap_done_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        flush_pend_ff;

	// bus decode; ack follows one cycle after the request
	wire         bus_req = WB_CYC_I & WB_STB_I;
	wire         bus_new = bus_req & ~ack_ff;
	wire         wr      = bus_req & WB_WE_I & ack_ff;
	wire  [7:0]  idx     = WB_ADR_I[9:2];
	wire         in_map  = (WB_ADR_I[31:10] == 22'h0);

	wire  [7:0]  max_req = ov1_ff[gpr_pkg::OV1_MAXREQ_BIT] ?
	                       {3'h0, ov2_ff[4:0]} :
	                       gpr_pkg::MAX_REQ_FIXED;
	wire  [31:0] status_word = {max_req, 14'h0, 1'b1, 3'h0,
	                            misc_ff[5], misc_ff[4], 1'b0, misc_ff[2],
	                            ctl_ff[gpr_pkg::CTL_RATE2X_BIT],
	                            1'b1};
	wire  [15:0] dev_id = ov1_ff[gpr_pkg::OV1_DEVID_BIT] ?
	                      ovid_ff[15:0] : FIXED_DEVICE_ID;
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0; // unmapped and reserved read zero
		if (in_map) begin
			case (idx)
				gpr_pkg::IDX_DEVICE_ID:    rd_mux = {16'h0, dev_id};
				gpr_pkg::IDX_WINDOW_BASE:  rd_mux = win_base_ff;
				gpr_pkg::IDX_TLB_CONTROL:  rd_mux = tlb_ctl_ff;
				gpr_pkg::IDX_SIZE_MASK:    rd_mux = size_ff;
				gpr_pkg::IDX_TABLE_BASE:   rd_mux = tbl_base_ff;
				gpr_pkg::IDX_CAPABILITY:
					rd_mux = gpr_pkg::CAPABILITY_WORD;
				gpr_pkg::IDX_STATUS:       rd_mux = status_word;
				gpr_pkg::IDX_COMMAND:      rd_mux = cmd_ff;
				gpr_pkg::IDX_CONTROL:
					rd_mux = {24'h0, strap_ff, ctl_ff[6:0]};
				gpr_pkg::IDX_LATENCY:      rd_mux = lat_ff;
				gpr_pkg::IDX_MISC:         rd_mux = misc_ff;
				gpr_pkg::IDX_PAD_CONTROL:  rd_mux = pad_ff;
				gpr_pkg::IDX_DRIVE:        rd_mux = drive_ff;
				gpr_pkg::IDX_PAD_DELAY:    rd_mux = delay_ff;
				gpr_pkg::IDX_LATCH_SEL:    rd_mux = latch_ff;
				gpr_pkg::IDX_SCRATCH_LO:   rd_mux = scr_lo_ff;
				gpr_pkg::IDX_SCRATCH_HI:   rd_mux = scr_hi_ff;
				gpr_pkg::IDX_DRAM_TIMER:   rd_mux = dtim_ff;
				gpr_pkg::IDX_VIDEO_TIMER:  rd_mux = vtim_ff;
				gpr_pkg::IDX_OVERRIDE_ONE: rd_mux = ov1_ff;
				gpr_pkg::IDX_OVERRIDE_TWO: rd_mux = ov2_ff;
				gpr_pkg::IDX_OVERRIDE_ID:  rd_mux = ovid_ff;
				default:          rd_mux = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0;
		end else begin
			ack_ff <= bus_new;
			if (bus_new)
				dat_ff <= rd_mux;
		end
	end

	// masked writes keep reserved bits at zero
	`define GPR_REG(r, i, m, rv) \
	always_ff @(posedge CLOCK) begin \
		if (!RSTN) r <= gpr_pkg::rv; \
		else if (wr && in_map && idx == gpr_pkg::i) \
			r <= wmerge(r, WB_DAT_I, WB_SEL_I, gpr_pkg::m); \
	end
	`GPR_REG(win_base_ff, IDX_WINDOW_BASE,  MSK_WINDOW_BASE, RST_ZERO)
	`GPR_REG(tlb_ctl_ff,  IDX_TLB_CONTROL,  MSK_TLB_CONTROL, RST_ZERO)
	`GPR_REG(size_ff,     IDX_SIZE_MASK,    MSK_BYTE,        RST_ZERO)
	`GPR_REG(tbl_base_ff, IDX_TABLE_BASE,   MSK_TABLE_BASE,  RST_ZERO)
	`GPR_REG(cmd_ff,      IDX_COMMAND,      MSK_COMMAND,     RST_ZERO)
	`GPR_REG(ctl_ff,      IDX_CONTROL,      MSK_CONTROL,     RST_CONTROL)
	`GPR_REG(lat_ff,      IDX_LATENCY,      MSK_LATENCY,     RST_LATENCY)
	`GPR_REG(misc_ff,     IDX_MISC,         MSK_MISC,        RST_ZERO)
	`GPR_REG(pad_ff,      IDX_PAD_CONTROL,  MSK_PAD_CONTROL, RST_PAD_CONTROL)
	`GPR_REG(drive_ff,    IDX_DRIVE,        MSK_BYTE,        RST_DRIVE)
	`GPR_REG(delay_ff,    IDX_PAD_DELAY,    MSK_PAD_DELAY,   RST_ZERO)
	`GPR_REG(latch_ff,    IDX_LATCH_SEL,    MSK_LATCH_SEL,   RST_ZERO)
	`GPR_REG(scr_lo_ff,   IDX_SCRATCH_LO,   MSK_WORD,        RST_ZERO)
	`GPR_REG(scr_hi_ff,   IDX_SCRATCH_HI,   MSK_WORD,        RST_ZERO)
	`GPR_REG(dtim_ff,     IDX_DRAM_TIMER,   MSK_BYTE,        RST_ZERO)
	`GPR_REG(vtim_ff,     IDX_VIDEO_TIMER,  MSK_BYTE,        RST_ZERO)
	`GPR_REG(ov1_ff,      IDX_OVERRIDE_ONE, MSK_OVERRIDE_1,  RST_ZERO)
	`GPR_REG(ov2_ff,      IDX_OVERRIDE_TWO, MSK_OVERRIDE_2,  RST_ZERO)
	`GPR_REG(ovid_ff,     IDX_OVERRIDE_ID,  MSK_HALF,        RST_ZERO)
	`undef GPR_REG

	// strap caught by the first clock after reset release
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			strap_ff      <= 1'b0;
			strap_done_ff <= 1'b0;
		end else if (!strap_done_ff) begin
			strap_ff      <= PORT_DISABLE_STRAP;
			strap_done_ff <= 1'b1;
		end
	end

	// flush request: a write with the flush bit set arms it
	wire flush_wr = wr && in_map && idx == gpr_pkg::IDX_TLB_CONTROL &&
	                WB_SEL_I[0] && WB_DAT_I[gpr_pkg::TLB_FLUSH_BIT];
	wire tmg_now  = tbl_base_ff[gpr_pkg::BASE_TIMING_BIT];
	wire flush_go = (flush_pend_ff | flush_wr) & (tmg_now | DRAM_IDLE);
	always_ff @(posedge CLOCK) begin
		if (!RSTN)
			flush_pend_ff <= 1'b0;
		else
			flush_pend_ff <= (flush_pend_ff | flush_wr) & ~flush_go;
	end

	// window hit: size mask covers bits 27..20, 31..28 always compared
	gpr_pkg::gpr_req_t req_ff;
	gpr_state_t  state_ff;
	wire  [11:0] win_mask = {4'hf, size_ff[7:0]};
	wire         win_en   = tbl_base_ff[gpr_pkg::BASE_ENABLE_BIT];
	wire         win_hit  = win_en &
	                        (((req_ff.addr[31:20] ^ win_base_ff[31:20]) &
	                          win_mask) == 12'h0);
	wire         xlat_en  = tlb_ctl_ff[req_ff.src];
	wire  [19:0] vpage    = req_ff.addr[31:12];
	wire  [19:0] rel_page = vpage - {win_base_ff[31:20], 8'h0};
	// each entry is four bytes
	wire  [31:0] ent_addr = {tbl_base_ff[31:12], 12'h0} +
	                        {10'h0, rel_page, 2'b00};

	logic [19:0]                   tag_ff  [gpr_pkg::TLB_ENTRIES];
	logic [19:0]                   page_ff [gpr_pkg::TLB_ENTRIES];
	logic [gpr_pkg::TLB_IDX_W-1:0] age_ff  [gpr_pkg::TLB_ENTRIES];
	logic [gpr_pkg::TLB_ENTRIES-1:0] val_ff;
	logic [gpr_pkg::TLB_ENTRIES-1:0] hit_vec;
	logic [gpr_pkg::TLB_IDX_W-1:0] hit_idx, vic_idx;
	logic [19:0]                   hit_page;

	always_comb begin
		hit_idx  = '0;
		hit_page = 20'h0;
		vic_idx  = '0;
		for (int i = gpr_pkg::TLB_ENTRIES - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				hit_idx  = gpr_pkg::TLB_IDX_W'(i);
				hit_page = page_ff[i];
			end
		end
		// empty slot first, else the oldest (all-ones age)
		for (int i = 0; i < gpr_pkg::TLB_ENTRIES; i++) begin
			if (&age_ff[i])
				vic_idx = gpr_pkg::TLB_IDX_W'(i);
		end
		for (int i = gpr_pkg::TLB_ENTRIES - 1; i >= 0; i--) begin
			if (!val_ff[i])
				vic_idx = gpr_pkg::TLB_IDX_W'(i);
		end
	end

	wire                 tlb_hit = |hit_vec;
	wire                 do_hit  = (state_ff == ST_CHECK) & win_hit &
	                               xlat_en & tlb_hit;
	wire                 do_fill = (state_ff == ST_FETCH) & FETCH_ACK;
	wire                 touch   = do_hit | do_fill;
	wire [gpr_pkg::TLB_IDX_W-1:0] t_idx = do_fill ? vic_idx : hit_idx;

	// ages stay a permutation so the oldest is always unique
	genvar g;
	generate
		for (g = 0; g < gpr_pkg::TLB_ENTRIES; g++) begin : g_tlb
			localparam logic [gpr_pkg::TLB_IDX_W-1:0] SLOT =
				gpr_pkg::TLB_IDX_W'(g);
			assign hit_vec[g] = val_ff[g] & (tag_ff[g] == vpage);
			always_ff @(posedge CLOCK) begin
				if (!RSTN) begin
					val_ff[g]  <= 1'b0;
					tag_ff[g]  <= 20'h0;
					page_ff[g] <= 20'h0;
					age_ff[g]  <= SLOT;
				end else begin
					if (flush_go)
						val_ff[g] <= 1'b0;
					else if (do_fill && vic_idx == SLOT)
						val_ff[g] <= 1'b1;
					if (do_fill && vic_idx == SLOT) begin
						tag_ff[g]  <= vpage;
						page_ff[g] <= FETCH_DATA[31:12];
					end
					if (touch && t_idx == SLOT)
						age_ff[g] <= '0;
					else if (touch && age_ff[g] < age_ff[t_idx])
						age_ff[g] <= age_ff[g] + 1'b1;
				end
			end
		end
	endgenerate

	logic     ready_ff, ans_v_ff, fetch_ff;
	gpr_pkg::gpr_ans_t ans_ff;
	logic [31:0] faddr_ff;

	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			state_ff <= ST_IDLE;
			req_ff   <= '0;
			ready_ff <= 1'b0;
			ans_v_ff <= 1'b0;
			ans_ff   <= '0;
			fetch_ff <= 1'b0;
			faddr_ff <= 32'h0;
		end else begin
			ans_v_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					ready_ff <= 1'b1;
					if (XLAT_REQ_VALID && ready_ff) begin
						req_ff   <= XLAT_REQ;
						ready_ff <= 1'b0;
						state_ff <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					ans_ff.no_snoop <= win_hit;
					if (!win_hit || !xlat_en) begin
						ans_ff.addr       <= req_ff.addr;
						ans_ff.translated <= 1'b0;
						ans_v_ff          <= 1'b1;
						state_ff          <= ST_IDLE;
					end else if (tlb_hit) begin
						ans_ff.addr <= {hit_page, req_ff.addr[11:0]};
						ans_ff.translated <= 1'b1;
						ans_v_ff          <= 1'b1;
						state_ff          <= ST_IDLE;
					end else begin
						fetch_ff <= 1'b1;
						faddr_ff <= ent_addr;
						state_ff <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (FETCH_ACK) begin
						fetch_ff          <= 1'b0;
						ans_ff.addr <= {FETCH_DATA[31:12], req_ff.addr[11:0]};
						ans_ff.translated <= 1'b1;
						ans_v_ff          <= 1'b1;
						state_ff          <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// grant: parking holds it; a peer request breaks a park unless boosted
	logic gnt_ff, peer_gnt_ff;
	wire  g_req  = ~GRAPHICS_REQUEST_IN_N & ~strap_ff;
	wire  park   = ctl_ff[gpr_pkg::CTL_PARK_BIT];
	wire  boost  = ctl_ff[gpr_pkg::CTL_BOOST_BIT];
	wire  hold   = gnt_ff & park & g_req & ~DATA_PHASE_READY &
	               (~PEER_REQUEST | boost);
	wire  fresh  = ~gnt_ff & ~peer_gnt_ff & g_req & ~PEER_REQUEST;
	wire  nxt_gnt = hold | fresh;
	always_ff @(posedge CLOCK) begin
		if (!RSTN) begin
			gnt_ff      <= 1'b0;
			peer_gnt_ff <= 1'b0;
		end else begin
			gnt_ff      <= nxt_gnt;
			peer_gnt_ff <= PEER_REQUEST & ~nxt_gnt;
		end
	end

	assign WB_ACK_O             = ack_ff;
	assign WB_DAT_O             = dat_ff;
	assign XLAT_READY           = ready_ff;
	assign XLAT_ANS_VALID       = ans_v_ff;
	assign XLAT_ANS             = ans_ff;
	assign FETCH_REQ            = fetch_ff;
	assign FETCH_ADDR           = faddr_ff;
	assign GRAPHICS_GRANT_OUT_N = ~gnt_ff;
	assign PEER_GRANT           = peer_gnt_ff;
	assign IN_ORDER_MODE        = ctl_ff[gpr_pkg::CTL_ORDER_BIT];
	assign TURNAROUND_1T        = ctl_ff[gpr_pkg::CTL_TURN_BIT];
	assign DATA_LATENCY         = lat_ff[3:0];
	assign FIRST_READY_SEL      = lat_ff[gpr_pkg::LAT_FIRST_BIT];
	assign DRAM_LATCH_EXTERNAL  = latch_ff[0];
	assign DRAM_ARB_TIMER       = dtim_ff[7:0];
	assign VIDEO_TIMER          = vtim_ff[7:0];
	assign PORT_ENABLE          = cmd_ff[gpr_pkg::CMD_PORT_BIT];
	assign SIDEBAND_ENABLE      = cmd_ff[gpr_pkg::CMD_SIDE_BIT];
	assign RATE_ENABLE          = cmd_ff[2:0];
endmodule // gpr_regs_top

// [pkg/gpr_pkg.sv]
// package: offsets, masks, reset values and carriers of the remap config block
package gpr_pkg;
	// register word indexes, byte address is four times the index
	localparam logic [7:0] IDX_DEVICE_ID    = 8'h02;
	localparam logic [7:0] IDX_WINDOW_BASE  = 8'h10;
	localparam logic [7:0] IDX_TLB_CONTROL  = 8'h80;
	localparam logic [7:0] IDX_SIZE_MASK    = 8'h84;
	localparam logic [7:0] IDX_TABLE_BASE   = 8'h88;
	localparam logic [7:0] IDX_CAPABILITY   = 8'ha0;
	localparam logic [7:0] IDX_STATUS       = 8'ha4;
	localparam logic [7:0] IDX_COMMAND      = 8'ha8;
	localparam logic [7:0] IDX_CONTROL      = 8'hac;
	localparam logic [7:0] IDX_LATENCY      = 8'had;
	localparam logic [7:0] IDX_MISC         = 8'hae;
	localparam logic [7:0] IDX_PAD_CONTROL  = 8'hb0;
	localparam logic [7:0] IDX_DRIVE        = 8'hb1;
	localparam logic [7:0] IDX_PAD_DELAY    = 8'hb2;
	localparam logic [7:0] IDX_LATCH_SEL    = 8'he0;
	localparam logic [7:0] IDX_SCRATCH_LO   = 8'hf0;
	localparam logic [7:0] IDX_SCRATCH_HI   = 8'hf1;
	localparam logic [7:0] IDX_DRAM_TIMER   = 8'hf8;
	localparam logic [7:0] IDX_VIDEO_TIMER  = 8'hf9;
	localparam logic [7:0] IDX_OVERRIDE_ONE = 8'hfc;
	localparam logic [7:0] IDX_OVERRIDE_TWO = 8'hfd;
	localparam logic [7:0] IDX_OVERRIDE_ID  = 8'hfe;
	// writable bit masks
	localparam logic [31:0] MSK_WINDOW_BASE = 32'hfff0_0000;
	localparam logic [31:0] MSK_TLB_CONTROL = 32'h0000_008f;
	localparam logic [31:0] MSK_TABLE_BASE  = 32'hffff_f006;
	localparam logic [31:0] MSK_COMMAND     = 32'h0000_0337;
	localparam logic [31:0] MSK_CONTROL     = 32'h0000_007f;
	localparam logic [31:0] MSK_LATENCY     = 32'h0000_001f;
	localparam logic [31:0] MSK_MISC        = 32'h0000_0034;
	localparam logic [31:0] MSK_PAD_CONTROL = 32'h0000_00c0;
	localparam logic [31:0] MSK_PAD_DELAY   = 32'h0000_0091;
	localparam logic [31:0] MSK_LATCH_SEL   = 32'h0000_0001;
	localparam logic [31:0] MSK_OVERRIDE_1  = 32'h0000_00f3;
	localparam logic [31:0] MSK_OVERRIDE_2  = 32'h0000_001f;
	localparam logic [31:0] MSK_BYTE        = 32'h0000_00ff;
	localparam logic [31:0] MSK_HALF        = 32'h0000_ffff;
	localparam logic [31:0] MSK_WORD        = 32'hffff_ffff;
	// reset values
	localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
	localparam logic [31:0] RST_CONTROL     = 32'h0000_0008;
	localparam logic [31:0] RST_LATENCY     = 32'h0000_0002;
	localparam logic [31:0] RST_PAD_CONTROL = 32'h0000_0080;
	localparam logic [31:0] RST_DRIVE       = 32'h0000_0063;
	// fixed read values
	localparam logic [31:0] CAPABILITY_WORD = 32'h0020_c002;
	localparam logic [7:0]  MAX_REQ_FIXED   = 8'h1f;
	// field positions
	localparam int TLB_FLUSH_BIT   = 7;
	localparam int BASE_TIMING_BIT = 2;
	localparam int BASE_ENABLE_BIT = 1;
	localparam int CTL_BOOST_BIT   = 4;
	localparam int CTL_RATE2X_BIT  = 3;
	localparam int CTL_ORDER_BIT   = 2;
	localparam int CTL_PARK_BIT    = 1;
	localparam int CTL_TURN_BIT    = 0;
	localparam int LAT_FIRST_BIT   = 4;
	localparam int OV1_MAXREQ_BIT  = 1;
	localparam int OV1_DEVID_BIT   = 0;
	localparam int CMD_PORT_BIT    = 8;
	localparam int CMD_SIDE_BIT    = 9;
	// TLB geometry
	localparam int TLB_ENTRIES = 16;
	localparam int TLB_IDX_W   = 4;
	// access source codes; each equals its translate-enable bit position
	localparam logic [1:0] SRC_PORT    = 2'h0;
	localparam logic [1:0] SRC_CPU     = 2'h1;
	localparam logic [1:0] SRC_GMASTER = 2'h2;
	localparam logic [1:0] SRC_PCI     = 2'h3;
	typedef struct packed {
		logic [31:0] addr;
		logic [1:0]  src;
	} gpr_req_t;
	typedef struct packed {
		logic [31:0] addr;
		logic        translated;
		logic        no_snoop;
	} gpr_ans_t;
endpackage

// [tb/gpr_fetch_model.sv]
// memory side model answering translation table entry fetches
module gpr_fetch_model (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        slow,
	input wire logic        req,
	input wire logic [31:0] addr,
	output logic            ack,
	output logic [31:0]     data,
	output int              count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_ff;
	always @(posedge clk) begin
		ack <= 1'b0;
		// idle data toggles so a stale entry is never mistaken for fresh
		data <= ~data;
		if (!rstn) begin
			wait_ff <= 4'h0;
			count <= 0;
			data <= 32'h0;
		end else if (req && !ack) begin
			if (wait_ff >= (slow ? 4'h6 : 4'h0)) begin
				ack <= 1'b1;
				data <= {addr[31:12] ^ 20'h5a5a5, 12'h0};
				wait_ff <= 4'h0;
				count <= count + 1;
			end else
				wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule // gpr_fetch_model

// [tb/gpr_regs_chk.sv]
// checker: bus, translation and grant relations of the remap config block
module gpr_regs_chk (
	input wire logic              CLOCK,
	input wire logic              RSTN,
	input wire logic              WB_CYC_I,
	input wire logic              WB_STB_I,
	input wire logic              WB_WE_I,
	input wire logic [31:0]       WB_ADR_I,
	input wire logic [3:0]        WB_SEL_I,
	input wire logic [31:0]       WB_DAT_I,
	input wire logic [31:0]       WB_DAT_O,
	input wire logic              WB_ACK_O,
	input wire logic              XLAT_REQ_VALID,
	input wire logic              XLAT_READY,
	input wire logic              XLAT_ANS_VALID,
	input wire gpr_pkg::gpr_ans_t XLAT_ANS,
	input wire logic              FETCH_REQ,
	input wire logic [31:0]       FETCH_ADDR,
	input wire logic              FETCH_ACK,
	input wire logic              GRAPHICS_REQUEST_IN_N,
	input wire logic              PEER_REQUEST,
	input wire logic              DATA_PHASE_READY,
	input wire logic              GRAPHICS_GRANT_OUT_N,
	input wire logic              IN_ORDER_MODE,
	input wire logic              TURNAROUND_1T
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] ctl_ff;
	logic       rd_ack;
	logic       ctl_wr;
	assign rd_ack = WB_ACK_O && !WB_WE_I;
	assign ctl_wr = WB_ACK_O && WB_WE_I && WB_ADR_I == 32'h2b0 && WB_SEL_I[0];
	// shadow of the control byte, the strap bit is left out
	always_ff @(posedge CLOCK) begin
		if (!RSTN)
			ctl_ff <= 7'h08;
		else if (ctl_wr)
			ctl_ff <= WB_DAT_I[6:0];
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	sequence take_s;
		XLAT_REQ_VALID && XLAT_READY;
	endsequence
	sequence answer_s;
		##1 !XLAT_READY ##[1:40] XLAT_ANS_VALID;
	endsequence
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_delay_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	unmapped_zero_a: assert property (
		rd_ack && WB_ADR_I[31:10] != 22'h0 |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	cap_word_a: assert property (
		rd_ack && WB_ADR_I == 32'h280 |-> WB_DAT_O == gpr_pkg::CAPABILITY_WORD)
		else $error("capability word wrong");
	status_fixed_a: assert property (rd_ack && WB_ADR_I == 32'h290 |->
		WB_DAT_O[23:6] == 18'h00008 && !WB_DAT_O[3] && WB_DAT_O[0])
		else $error("status fixed bits wrong");
	cmd_reserved_a: assert property (rd_ack && WB_ADR_I == 32'h2a0 |->
		(WB_DAT_O & ~gpr_pkg::MSK_COMMAND) == 32'h0)
		else $error("command reserved bits set");
	base_reserved_a: assert property (rd_ack && WB_ADR_I == 32'h220 |->
		WB_DAT_O[11:3] == 9'h0 && !WB_DAT_O[0])
		else $error("table base low bits set");
	xlat_answer_a: assert property (take_s |-> answer_s)
		else $error("translation answer missing");
	snoop_flag_a: assert property (
		XLAT_ANS_VALID && XLAT_ANS.translated |-> XLAT_ANS.no_snoop)
		else $error("translated access snooped");
	fetch_hold_a: assert property (FETCH_REQ && !FETCH_ACK |=>
		FETCH_REQ && $stable(FETCH_ADDR))
		else $error("fetch request dropped early");
	park_hold_a: assert property (!GRAPHICS_GRANT_OUT_N && ctl_ff[1] &&
		!GRAPHICS_REQUEST_IN_N && !DATA_PHASE_READY && !PEER_REQUEST
		|=> !GRAPHICS_GRANT_OUT_N)
		else $error("parked grant lost");
	no_park_a: assert property (
		!GRAPHICS_GRANT_OUT_N && !ctl_ff[1] |=> GRAPHICS_GRANT_OUT_N)
		else $error("unparked grant held");
	ctl_mirror_a: assert property (IN_ORDER_MODE == ctl_ff[2] &&
		TURNAROUND_1T == ctl_ff[0])
		else $error("control outputs differ from register");
endmodule // gpr_regs_chk

bind gpr_regs_top gpr_regs_chk i_chk (.CLOCK(CLOCK), .RSTN(RSTN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .XLAT_REQ_VALID(XLAT_REQ_VALID),
	.XLAT_READY(XLAT_READY), .XLAT_ANS_VALID(XLAT_ANS_VALID),
	.XLAT_ANS(XLAT_ANS), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
	.FETCH_ACK(FETCH_ACK), .GRAPHICS_REQUEST_IN_N(GRAPHICS_REQUEST_IN_N),
	.PEER_REQUEST(PEER_REQUEST), .DATA_PHASE_READY(DATA_PHASE_READY),
	.GRAPHICS_GRANT_OUT_N(GRAPHICS_GRANT_OUT_N),
	.IN_ORDER_MODE(IN_ORDER_MODE), .TURNAROUND_1T(TURNAROUND_1T));

// [tb/gpr_regs_top_bench.sv]
// bench: register, translation and grant scenarios of the remap config block
module gpr_regs_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] DEV_ID = 16'h3c3c; // arbitrary value
	localparam logic [31:0] XADDR = {20'h00100 ^ 20'h5a5a5, 12'h234};
	logic CLOCK, RSTN, cyc, stb, we, xv, f_ack, idle, strap, req_n, peer;
	logic dpr, slow, ack, xrdy, xav, f_req, gnt_n, pgnt, ino, t1, frs, dle;
	logic pen, sben;
	logic [31:0] adr, wdat, f_data, rdat, dat_o, f_adr;
	logic [3:0] sel, lat;
	logic [7:0] arbt, vidt;
	logic [2:0] rate;
	gpr_pkg::gpr_req_t xr;
	gpr_pkg::gpr_ans_t ans, xans;
	int fails, compares, fcount;
	gpr_regs_top #(.FIXED_DEVICE_ID(DEV_ID)) i_dut (.CLOCK(CLOCK), .RSTN(RSTN),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.XLAT_REQ_VALID(xv), .XLAT_REQ(xr), .XLAT_READY(xrdy),
		.XLAT_ANS_VALID(xav), .XLAT_ANS(xans), .FETCH_REQ(f_req),
		.FETCH_ADDR(f_adr), .FETCH_ACK(f_ack), .FETCH_DATA(f_data),
		.DRAM_IDLE(idle), .PORT_DISABLE_STRAP(strap),
		.GRAPHICS_REQUEST_IN_N(req_n), .PEER_REQUEST(peer),
		.DATA_PHASE_READY(dpr), .GRAPHICS_GRANT_OUT_N(gnt_n),
		.PEER_GRANT(pgnt), .IN_ORDER_MODE(ino), .TURNAROUND_1T(t1),
		.DATA_LATENCY(lat), .FIRST_READY_SEL(frs), .DRAM_LATCH_EXTERNAL(dle),
		.DRAM_ARB_TIMER(arbt), .VIDEO_TIMER(vidt), .PORT_ENABLE(pen),
		.SIDEBAND_ENABLE(sben), .RATE_ENABLE(rate));
	gpr_fetch_model i_model (.clk(CLOCK), .rstn(RSTN), .slow(slow),
		.req(f_req), .addr(f_adr), .ack(f_ack), .data(f_data),
		.count(fcount));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_sim;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// wait at most n_max edges for a flag sampled at the edge
	task automatic wait_for(ref logic flag, input int n_max);
		int n;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (flag !== 1'b1 && n < n_max);
		if (n >= n_max) begin
			fails++;
			end_sim();
		end
	endtask
	task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		wait_for(ack, 50);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task xl(input logic [1:0] s, input logic [31:0] a);
		@(posedge CLOCK);
		xr <= {a, s};
		xv <= 1'b1;
		wait_for(xrdy, 50);
		xv <= 1'b0;
		wait_for(xav, 100);
		ans = xans;
	endtask
	initial begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (100000) @(posedge CLOCK);
		fails++;
		end_sim();
	end
	initial begin
		{RSTN, cyc, stb, we, xv, strap, peer, dpr, slow} = '0;
		{adr, wdat, sel, xr} = '0;
		{idle, req_n} = 2'b11;
		fails = 0;
		compares = 0;
		repeat (5) @(posedge CLOCK);
		RSTN <= 1'b1;
		rd(32'h280, gpr_pkg::CAPABILITY_WORD);
		rd(32'h290, 32'h1f000203);
		rd(32'h2a0, 32'h0);
		rd(32'h2b0, 32'h08);
		rd(32'h2b4, 32'h02);
		rd(32'h220, 32'h0);
		wb(1'b1, 32'h404, '1);
		rd(32'h404, 32'h0);
		wb(1'b1, 32'h2a0, '1);
		rd(32'h2a0, 32'h337);
		chk({27'h0, pen, sben, rate}, 32'h1f);
		wb(1'b1, 32'h2b8, '1);
		rd(32'h2b8, 32'h34);
		rd(32'h290, 32'h1f000237);
		wb(1'b1, 32'h2b0, 32'h05);
		rd(32'h290, 32'h1f000235);
		chk({30'h0, ino, t1}, 32'h3);
		wb(1'b1, 32'h2b4, '1);
		wb(1'b1, 32'h380, '1);
		wb(1'b1, 32'h3e0, '1);
		wb(1'b1, 32'h3e4, 32'h5a);
		rd(32'h3e0, 32'hff);
		chk({27'h0, frs, lat}, 32'h1f);
		chk({31'h0, dle}, 32'h1);
		chk({16'h0, arbt, vidt}, 32'hff5a);
		wb(1'b1, 32'h3f4, 32'h15);
		wb(1'b1, 32'h3f0, 32'h02);
		rd(32'h290, 32'h15000235);
		wb(1'b0, 32'h08, 32'h0);
		chk({16'h0, rdat[15:0]}, {16'h0, DEV_ID});
		wb(1'b1, 32'h3f8, 32'h1234);
		wb(1'b1, 32'h3f0, 32'h01);
		wb(1'b0, 32'h08, 32'h0);
		chk({16'h0, rdat[15:0]}, 32'h1234);
		wb(1'b1, 32'h220, '1);
		rd(32'h220, 32'hfffff006);
		wb(1'b1, 32'h40, 32'h10000000);
		wb(1'b1, 32'h210, 32'hfc);
		wb(1'b1, 32'h220, 32'h00100006);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, 32'h200, 32'h1 << s);
			xl(2'(s), 32'h10001234);
			chk({ans.addr[31:2], ans.translated, ans.no_snoop},
				{XADDR[31:2], 2'b11});
			xl(2'(s + 1), 32'h10001234);
			chk({ans.addr[31:2], ans.translated, ans.no_snoop},
				{30'h0400048d, 2'b01});
		end
		chk(fcount, 32'h1);
		slow <= 1'b1;
		wb(1'b1, 32'h200, 32'h81);
		xl(2'h0, 32'h10001234);
		chk(fcount, 32'h2);
		wb(1'b1, 32'h220, 32'h00100002);
		idle <= 1'b0;
		wb(1'b1, 32'h200, 32'h81);
		xl(2'h0, 32'h10001234);
		chk(fcount, 32'h2);
		idle <= 1'b1;
		repeat (3) @(posedge CLOCK);
		xl(2'h0, 32'h10001234);
		chk(fcount, 32'h3);
		xl(2'h1, 32'h20000000);
		chk({ans.addr[31:2], ans.translated, ans.no_snoop}, 32'h20000000);
		wb(1'b1, 32'h2b0, 32'h0a);
		req_n <= 1'b0;
		repeat (6) @(posedge CLOCK);
		chk({31'h0, gnt_n}, 32'h0);
		dpr <= 1'b1;
		@(posedge CLOCK);
		dpr <= 1'b0;
		peer <= 1'b1;
		repeat (3) @(posedge CLOCK);
		chk({30'h0, gnt_n, pgnt}, 32'h3);
		peer <= 1'b0;
		wb(1'b1, 32'h2b0, 32'h1a);
		peer <= 1'b1;
		repeat (3) @(posedge CLOCK);
		chk({30'h0, gnt_n, pgnt}, 32'h0);
		{peer, req_n} <= 2'b01;
		wb(1'b1, 32'h2b0, 32'h08);
		req_n <= 1'b0;
		repeat (6) @(posedge CLOCK);
		req_n <= 1'b1;
		strap <= 1'b1;
		RSTN <= 1'b0;
		repeat (5) @(posedge CLOCK);
		RSTN <= 1'b1;
		rd(32'h2b0, 32'h88);
		end_sim();
	end
endmodule // gpr_regs_top_bench
